// >>> common/esp_pkg.sv
/*
  Shared constants for the serial transmit payload input block: register
  map, field positions, reset values, E3 frame geometry and pin indices.
  Assumes an 8-bit register port with 16-bit byte addresses.
*/
package esp_pkg;

  // Register port geometry.
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;

  // Register offsets.
  localparam logic [15:0] OPMODE_OFFSET = 16'h1100;
  localparam logic [15:0] STATUS_OFFSET = 16'h1101;
  localparam logic [15:0] FRAMES_OFFSET = 16'h1102;

  // Reset values and field positions of the operating mode register.
  localparam logic [7:0]  OPMODE_RESET  = 8'h28;
  localparam int unsigned TIMSEL_LSB    = 0;
  localparam int unsigned TIMSEL_MSB    = 1;
  localparam logic [1:0]  TIMSEL_LOOP   = 2'h0;
  localparam logic [1:0]  TIMSEL_SLAVE  = 2'h1;

  // Status register field positions.
  localparam int unsigned STAT_SERIAL   = 0;
  localparam int unsigned STAT_RUN      = 1;
  localparam int unsigned STAT_HUNT     = 2;

  // E3 frame: 1536 bits, the first 12 are overhead (FAS, A and N).
  localparam int unsigned CNT_W         = 11;
  localparam logic [10:0] LAST_BIT      = 11'h5ff;
  localparam logic [10:0] OH_BITS       = 11'h00c;
  localparam logic [10:0] OH_LEAD_LAST  = 11'h00b;

  // Indices of the pins passed through the synchroniser.
  localparam int unsigned SYNC_W        = 5;
  localparam int unsigned PIN_RCLK      = 0;
  localparam int unsigned PIN_LCLK      = 1;
  localparam int unsigned PIN_REF       = 2;
  localparam int unsigned PIN_SEL       = 3;
  localparam int unsigned PIN_DATA      = 4;

  typedef enum logic [1:0] {
    ESP_IDLE,
    ESP_HUNT,
    ESP_RUN
  } esp_state_t;

endpackage : esp_pkg

// >>> rtl/esp_sync.sv
/*
  Two-flip-flop synchroniser for the block's asynchronous pins, with a
  third stage that holds the previous sample for edge detection.
  Assumes a single free-running system clock and an active-low reset.
*/
`timescale 1ns/1ps
module esp_sync (
  // Clock and reset.
  input  wire logic                        clk,
  input  wire logic                        rstn,
  // Raw pins and synchronised views.
  input  wire logic [esp_pkg::SYNC_W-1:0]  pin_raw,
  output logic      [esp_pkg::SYNC_W-1:0]  pin_lvl,
  output logic      [esp_pkg::SYNC_W-1:0]  pin_old,
  output logic      [esp_pkg::SYNC_W-1:0]  pin_rise
);

  logic [esp_pkg::SYNC_W-1:0] meta_q;
  logic [esp_pkg::SYNC_W-1:0] lvl_q;
  logic [esp_pkg::SYNC_W-1:0] old_q;

  ////////////////////////////////////////////////////////////////////////////

  // The first stage feeds only the second; nothing else looks at it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      lvl_q  <= '0;
      old_q  <= '0;
    end else begin
      meta_q <= pin_raw;
      lvl_q  <= meta_q;
      old_q  <= lvl_q;
    end
  end

  assign pin_lvl  = lvl_q;
  assign pin_old  = old_q;
  assign pin_rise = lvl_q & ~old_q;

endmodule : esp_sync

// >>> rtl/esp_serial_input.sv
/*
  Serial transmit payload input of an E3 framer: paces the link from the
  recovered line clock or the local transmit clock, counts frame bits,
  flags overhead ahead of time, marks frame ends and hands payload bits on.
  Assumes the bit clocks are far slower than clk so each edge is seen.
*/
`timescale 1ns/1ps
module esp_serial_input (
  // Clock and reset.
  input  wire logic                        clk,
  input  wire logic                        rstn,
  // Register port.
  input  wire logic [esp_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [esp_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [esp_pkg::DATA_W-1:0]  reg_rdata,
  // Pins toward the line and the terminal equipment.
  input  wire logic                        serial_parallel_select_pin,
  input  wire logic                        recovered_line_clock_in,
  input  wire logic                        tx_local_clock_in,
  input  wire logic                        tx_frame_reference_in,
  input  wire logic                        tx_serial_payload_in,
  output logic                             recovered_line_clock_out,
  output logic                             tx_frame_end_pulse,
  output logic                             tx_overhead_indicator,
  output logic                             rx_serial_mode,
  // Payload toward the frame generator.
  output logic                             payload_bit,
  output logic                             payload_bit_valid,
  output logic                             frame_start
);

  logic [esp_pkg::SYNC_W-1:0] pin_raw;
  logic [esp_pkg::SYNC_W-1:0] pin_lvl;
  logic [esp_pkg::SYNC_W-1:0] pin_old;
  logic [esp_pkg::SYNC_W-1:0] pin_rise;
  logic [7:0]                 opmode_q;
  logic [7:0]                 frames_q;
  logic [7:0]                 rdata_q;
  logic [1:0]                 timsel;
  logic [1:0]                 timsel_q;
  logic [1:0]                 wr_timsel;
  logic                       serial_mode;
  logic                       mode_ok;
  logic                       bit_stb;
  logic                       ref_smp;
  logic                       ref_prev_q;
  logic                       ref_rise;
  logic                       active;
  logic [esp_pkg::CNT_W-1:0]  cnt_q;
  logic [esp_pkg::CNT_W-1:0]  cur_bit;
  logic [esp_pkg::CNT_W-1:0]  nxt_bit;
  esp_pkg::esp_state_t        state_q;
  logic                       rclk_q;
  logic                       fend_q;
  logic                       oh_q;
  logic                       rxser_q;
  logic                       pbit_q;
  logic                       pvalid_q;
  logic                       fstart_q;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = (a == o);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation.

  assign pin_raw = {tx_serial_payload_in, serial_parallel_select_pin,
                    tx_frame_reference_in, tx_local_clock_in,
                    recovered_line_clock_in};

  esp_sync u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .pin_raw  (pin_raw),
    .pin_lvl  (pin_lvl),
    .pin_old  (pin_old),
    .pin_rise (pin_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      opmode_q <= esp_pkg::OPMODE_RESET;
    end else if (reg_wr && hit(reg_addr, esp_pkg::OPMODE_OFFSET)) begin
      opmode_q <= reg_wdata;
    end
  end

  assign timsel    = opmode_q[esp_pkg::TIMSEL_MSB:esp_pkg::TIMSEL_LSB];
  assign wr_timsel = reg_wdata[esp_pkg::TIMSEL_MSB:esp_pkg::TIMSEL_LSB];

  // Unmapped addresses read as zero; data stand only the cycle after.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= '0;
    end else if (!reg_rd) begin
      rdata_q <= '0;
    end else if (hit(reg_addr, esp_pkg::OPMODE_OFFSET)) begin
      rdata_q <= opmode_q;
    end else if (hit(reg_addr, esp_pkg::STATUS_OFFSET)) begin
      rdata_q <= '0;
      rdata_q[esp_pkg::STAT_SERIAL] <= serial_mode;
      rdata_q[esp_pkg::STAT_RUN]    <= (state_q == esp_pkg::ESP_RUN);
      rdata_q[esp_pkg::STAT_HUNT]   <= (state_q == esp_pkg::ESP_HUNT);
    end else if (hit(reg_addr, esp_pkg::FRAMES_OFFSET)) begin
      rdata_q <= frames_q;
    end else begin
      rdata_q <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode selection and bit pacing.

  assign serial_mode = ~pin_lvl[esp_pkg::PIN_SEL];
  assign mode_ok = (timsel == esp_pkg::TIMSEL_LOOP) ||
                   (timsel == esp_pkg::TIMSEL_SLAVE);

  // The bit clock is chosen by the timing reference select field.
  assign bit_stb = (timsel == esp_pkg::TIMSEL_LOOP) ?
                   pin_rise[esp_pkg::PIN_RCLK] :
                   pin_rise[esp_pkg::PIN_LCLK];

  // The reference is compared with its sample from the previous bit clock
  // edge; an asynchronous reference would misplace the frame.
  assign ref_smp  = pin_old[esp_pkg::PIN_REF];
  assign ref_rise = (timsel == esp_pkg::TIMSEL_SLAVE) &&
                    ref_smp && !ref_prev_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ref_prev_q <= 1'b0;
    end else if (bit_stb) begin
      ref_prev_q <= ref_smp;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timsel_q <= esp_pkg::TIMSEL_LOOP;
    end else begin
      timsel_q <= timsel;
    end
  end

  // Any change of mode drops back to idle so the frame restarts cleanly.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= esp_pkg::ESP_IDLE;
    end else if (!serial_mode || !mode_ok || timsel != timsel_q) begin
      state_q <= esp_pkg::ESP_IDLE;
    end else begin
      case (state_q)
        esp_pkg::ESP_IDLE: begin
          state_q <= (timsel == esp_pkg::TIMSEL_LOOP) ?
                     esp_pkg::ESP_RUN : esp_pkg::ESP_HUNT;
        end
        esp_pkg::ESP_HUNT: begin
          if (bit_stb && ref_rise) begin
            state_q <= esp_pkg::ESP_RUN;
          end
        end
        default: begin
          state_q <= esp_pkg::ESP_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame bit counter.

  // A reference edge marks the current bit as the frame's first bit.
  assign cur_bit = ref_rise ? '0 : cnt_q;
  assign nxt_bit = (cur_bit == esp_pkg::LAST_BIT) ? '0 :
                   esp_pkg::CNT_W'(cur_bit + 1'b1);
  assign active  = (state_q == esp_pkg::ESP_RUN) ||
                   (state_q == esp_pkg::ESP_HUNT && ref_rise);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (state_q == esp_pkg::ESP_IDLE) begin
      cnt_q <= '0;
    end else if (bit_stb && active) begin
      cnt_q <= nxt_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs.

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fend_q <= 1'b0;
      oh_q   <= 1'b0;
    end else if (state_q == esp_pkg::ESP_IDLE) begin
      fend_q <= 1'b0;
      oh_q   <= 1'b0;
    end else if (bit_stb) begin
      fend_q <= active && (cur_bit == esp_pkg::LAST_BIT);
      oh_q   <= active && (cur_bit == esp_pkg::LAST_BIT ||
                           cur_bit < esp_pkg::OH_LEAD_LAST);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rclk_q  <= 1'b0;
      rxser_q <= 1'b0;
    end else begin
      rclk_q  <= pin_lvl[esp_pkg::PIN_RCLK];
      rxser_q <= serial_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Payload hand-off.

  // Overhead positions are skipped: the terminal sends filler there.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pbit_q   <= 1'b0;
      pvalid_q <= 1'b0;
      fstart_q <= 1'b0;
    end else begin
      pvalid_q <= bit_stb && active && (cur_bit >= esp_pkg::OH_BITS);
      fstart_q <= bit_stb && active && (cur_bit == '0);
      if (bit_stb && active) begin
        pbit_q <= pin_old[esp_pkg::PIN_DATA];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frames_q <= '0;
    end else if (bit_stb && active && cur_bit == esp_pkg::LAST_BIT) begin
      frames_q <= frames_q + 8'h01;
    end
  end

  assign reg_rdata                = rdata_q;
  assign recovered_line_clock_out = rclk_q;
  assign tx_frame_end_pulse       = fend_q;
  assign tx_overhead_indicator    = oh_q;
  assign rx_serial_mode           = rxser_q;
  assign payload_bit              = pbit_q;
  assign payload_bit_valid        = pvalid_q;
  assign frame_start              = fstart_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_serial_gate: assert property (
    state_q != esp_pkg::ESP_IDLE |-> rx_serial_mode)
    else $error("framing active while not in serial mode");

  a_rx_serial: assert property (
    serial_parallel_select_pin [*4]
      |=> !rx_serial_mode)
    else $error("receive serial mode not following select pin");

  a_opmode_write: assert property (
    reg_wr && reg_addr == esp_pkg::OPMODE_OFFSET
      |=> timsel == $past(wr_timsel))
    else $error("timing select not taken from bits 1:0");

  a_loop_clock: assert property (
    $rose(payload_bit_valid) && timsel_q == esp_pkg::TIMSEL_LOOP
      && timsel == timsel_q |-> $past(pin_rise[esp_pkg::PIN_RCLK]))
    else $error("loop mode bit not paced by recovered clock");

  a_slave_clock: assert property (
    $rose(payload_bit_valid) && timsel_q == esp_pkg::TIMSEL_SLAVE
      && timsel == timsel_q |-> $past(pin_rise[esp_pkg::PIN_LCLK]))
    else $error("slave mode bit not paced by local clock");

  a_slave_start: assert property (
    bit_stb && ref_rise && state_q != esp_pkg::ESP_IDLE && serial_mode
      && timsel == timsel_q |=> frame_start && cnt_q == 11'h001)
    else $error("reference edge did not start a frame");

  a_hunt_quiet: assert property (
    state_q == esp_pkg::ESP_HUNT && $past(state_q) == esp_pkg::ESP_HUNT
      |-> !frame_start && !payload_bit_valid)
    else $error("frame slave started a frame on its own");

  a_end_single: assert property (
    tx_frame_end_pulse && bit_stb |=> !tx_frame_end_pulse)
    else $error("frame end held past one bit period");

  a_end_place: assert property (
    $rose(tx_frame_end_pulse) |-> cnt_q == '0 && payload_bit_valid)
    else $error("frame end not on last frame bit");

  a_oh_lead: assert property (
    $rose(tx_overhead_indicator) |-> (cnt_q == '0 && tx_frame_end_pulse)
      || (cnt_q == 11'h001 && frame_start))
    else $error("overhead flag not raised one bit ahead");

  a_oh_payload: assert property (
    payload_bit_valid |-> tx_overhead_indicator == tx_frame_end_pulse)
    else $error("payload taken while overhead flagged");

  c_loop_frame: cover property (
    timsel == esp_pkg::TIMSEL_LOOP && $rose(tx_frame_end_pulse));
  c_slave_start: cover property (
    timsel == esp_pkg::TIMSEL_SLAVE && frame_start);
  c_oh_run: cover property (
    $fell(tx_overhead_indicator) ##[1:20] payload_bit_valid);
  c_mode_switch: cover property (
    state_q == esp_pkg::ESP_RUN ##1 state_q == esp_pkg::ESP_IDLE);

endmodule : esp_serial_input

// >>> verification/esp_term_model.sv
/*
  Terminal equipment model that frames serial payload on the shared bit
  clock. Assumes the bench gates that same clock into the device pins.
*/
`timescale 1ns/1ps
module esp_term_model (
  // Bit clock and reset.
  input  wire logic clk_bit,
  input  wire logic rstn,
  // Bench controls.
  input  wire logic slave,
  input  wire logic go,
  // Pins facing the device.
  input  wire logic frame_end,
  output logic      data,
  output logic      frame_ref
);
  logic [10:0] pos_q;
  logic [10:0] pos_d;

  //////////////////////////////////////////////////////////////////////
  // The raw clock is used rather than the buffered copy, which shares a
  // clk edge with the frame end flop and would race with it.
  always_comb begin
    if (!slave && frame_end) begin
      pos_d = 11'h001;
    end else if (pos_q == 11'h5ff) begin
      pos_d = 11'h000;
    end else begin
      pos_d = pos_q + 11'h001;
    end
  end

  // Overhead slots carry a toggling filler so that any leak shows.
  always_ff @(posedge clk_bit or negedge rstn) begin
    if (!rstn) begin
      pos_q     <= 11'h000;
      data      <= 1'b0;
      frame_ref <= 1'b0;
    end else begin
      pos_q     <= pos_d;
      frame_ref <= slave & go & (pos_d == 11'h000);
      if (pos_d < 11'h00c) begin
        data <= ~data;
      end else begin
        data <= pos_d[0] ^ pos_d[3] ^ pos_d[7];
      end
    end
  end
endmodule : esp_term_model

// >>> verification/testbench.sv
/*
  Bench for the serial payload input: registers, loop timing, frame slave
  and the select pin. Assumes a bit clock of six clk periods.
*/
`timescale 1ns/1ps
module testbench;
  localparam int BIT_CLKS   = 6;
  localparam int FRAME_CLKS = 1536 * BIT_CLKS;
  localparam int TMO        = 85000;
  logic        clk, rstn, bclk, rec_on, loc_on, sel, slave, go, mon;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic        reg_wr, reg_rd, ser, fref, fe, oh, rsm, pbit, pval, fs, rco;
  logic        fs_seen;
  int          n_fail, compares, cyc, fe_w, oh_w, n_fe, n_fs, n_val, k;
  int          fs_cyc, n_rco, rco_fs, n_end;
  logic        rco_p, fe_p;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    bclk = 1'b0;
    #3;
    forever #60 bclk = ~bclk;
  end

  esp_serial_input u_dut (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_parallel_select_pin(sel),
    .recovered_line_clock_in(rec_on & bclk),
    .tx_local_clock_in(loc_on & bclk),
    .tx_frame_reference_in(fref), .tx_serial_payload_in(ser),
    .recovered_line_clock_out(rco), .tx_frame_end_pulse(fe),
    .tx_overhead_indicator(oh), .rx_serial_mode(rsm),
    .payload_bit(pbit), .payload_bit_valid(pval), .frame_start(fs)
  );
  esp_term_model u_term (
    .clk_bit(bclk), .rstn(rstn), .slave(slave), .go(go),
    .frame_end(fe), .data(ser), .frame_ref(fref)
  );

  //////////////////////////////////////////////////////////////////////
  function automatic logic pay(input int p);
    logic [10:0] q;
    q = 11'(p);
    return q[0] ^ q[3] ^ q[7];
  endfunction : pay

  task automatic chk(input string nm, input logic [15:0] got,
                     input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input string nm, input logic [15:0] a,
                        input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, {8'h00, reg_rdata & m}, {8'h00, e});
    @(posedge clk);
    #1;
    chk("read data idle", {8'h00, reg_rdata}, 16'h0000);
  endtask : rd_chk

  // Clocks are switched only while low, so no runt bit upsets the count.
  task automatic clk_sel(input logic r, input logic l);
    @(negedge bclk);
    @(posedge clk);
    rec_on <= r;
    loc_on <= l;
  endtask : clk_sel

  task automatic quiet(input string nm);
    int v0;
    v0 = n_val;
    repeat (40 * BIT_CLKS) @(posedge clk);
    chk(nm, 16'(n_val - v0), 16'h0000);
    $display("test %s done", nm);
  endtask : quiet

  task automatic wait_fs(input int n);
    int tgt;
    tgt = n_fs + n;
    for (int i = 0; i < 5 * FRAME_CLKS && n_fs < tgt; i++) begin
      @(posedge clk);
    end
    chk("frames seen", 16'(n_fs >= tgt), 16'h0001);
  endtask : wait_fs

  //////////////////////////////////////////////////////////////////////
  // Overhead width and payload are judged only after a full frame end was seen.
  always @(posedge clk) begin
    cyc++;
    if (pval === 1'b1) n_val++;
    if (fs === 1'b1) n_fs++;
    if (rco === 1'b1 && rco_p !== 1'b1) n_rco++;
    if (fe === 1'b1 && fe_p !== 1'b1) n_end++;
    rco_p = rco;
    fe_p  = fe;
    if (!mon) begin
      fe_w = 0;
      oh_w = 0;
      n_fe = 0;
      fs_seen = 1'b0;
    end else begin
      if (fe === 1'b1) fe_w++;
      else if (fe_w != 0) begin
        chk("frame end width", 16'(fe_w), 16'(BIT_CLKS));
        fe_w = 0;
        n_fe++;
      end
      if (oh === 1'b1) oh_w++;
      else if (oh_w != 0) begin
        if (n_fe > 0) chk("oh width", 16'(oh_w), 16'(12 * BIT_CLKS));
        oh_w = 0;
      end
      if (fs === 1'b1) begin
        chk("oh at start", {15'h0000, oh}, 16'h0001);
        if (fs_seen) begin
          chk("period", 16'(cyc - fs_cyc), 16'(FRAME_CLKS));
          chk("bits per frame", 16'(k), 16'h0600);
          chk("line clock out", 16'(n_rco - rco_fs),
              rec_on ? 16'h0600 : 16'h0000);
        end
        fs_seen = 1'b1;
        rco_fs = n_rco;
        fs_cyc = cyc;
        k = 12;
      end
      if (pval === 1'b1) begin
        if (k == 12) chk("oh off", {15'h0000, oh}, 16'h0000);
        if (n_fe > 0) chk("payload", {15'h0000, pbit}, {15'h0000, pay(k)});
        k++;
      end
    end
    if (cyc == TMO) begin
      n_fail++;
      $display("timeout after %0d cycles", cyc);
      tally_and_finish();
    end
  end

  initial begin
    rstn = 1'b0; reg_addr = 16'h0000; reg_wdata = 8'h00; reg_wr = 1'b0;
    reg_rd = 1'b0; sel = 1'b0; rec_on = 1'b0; loc_on = 1'b0;
    slave = 1'b0; go = 1'b0; mon = 1'b0; k = 0; fs_cyc = 0;
    n_fail = 0; compares = 0; cyc = 0; n_val = 0; n_fs = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    rd_chk("opmode reset", esp_pkg::OPMODE_OFFSET, 8'hff, esp_pkg::OPMODE_RESET);
    rd_chk("serial status", esp_pkg::STATUS_OFFSET, 8'h01, 8'h01);
    chk("rx serial", {15'h0000, rsm}, 16'h0001);
    wr(16'h1234, 8'ha5);
    rd_chk("unmapped", 16'h1234, 8'hff, 8'h00);
    wr(esp_pkg::OPMODE_OFFSET, 8'hc4);
    rd_chk("opmode rw", esp_pkg::OPMODE_OFFSET, 8'hff, 8'hc4);
    wr(esp_pkg::OPMODE_OFFSET, 8'h28);
    $display("test registers done");
    clk_sel(1'b0, 1'b1);
    quiet("loop local clock only");
    clk_sel(1'b1, 1'b0);
    mon <= 1'b1;
    wait_fs(3);
    mon <= 1'b0;
    $display("test loop timing done");
    wr(esp_pkg::OPMODE_OFFSET, 8'h29);
    rd_chk("opmode slave", esp_pkg::OPMODE_OFFSET, 8'h03, 8'h01);
    slave <= 1'b1;
    quiet("slave line clock only");
    clk_sel(1'b0, 1'b1);
    quiet("slave no reference");
    rd_chk("hunting", esp_pkg::STATUS_OFFSET, 8'h04, 8'h04);
    go  <= 1'b1;
    mon <= 1'b1;
    wait_fs(3);
    rd_chk("running", esp_pkg::STATUS_OFFSET, 8'h02, 8'h02);
    rd_chk("frames", esp_pkg::FRAMES_OFFSET, 8'hff, 8'(n_end));
    mon <= 1'b0;
    $display("test frame slave done");
    @(posedge clk);
    sel <= 1'b1;
    quiet("parallel select");
    chk("rx parallel", {15'h0000, rsm}, 16'h0000);
    rd_chk("parallel status", esp_pkg::STATUS_OFFSET, 8'h01, 8'h00);
    tally_and_finish();
  end
endmodule : testbench
